// ===== common/lsa_defines.svh
`ifndef LSA_DEFINES_SVH
`define LSA_DEFINES_SVH
// widths
`define LSA_DATA_W      32
`define LSA_REG_W       4
// pc-relative displacement span in bytes
`define LSA_PCREL_MAX   4095
// single-register offset spans
`define LSA_IMM_POS_MAX 4095
`define LSA_IMM_NEG_MAX 255
`define LSA_IDX_MAX     255
// two-word offset span
`define LSA_DUAL_MAX    1020
// second word of a pair sits one word above the first
`define LSA_WORD_BYTES  32'h0000_0004
// byte and halfword boundaries
`define LSA_BYTE_MSB    7
`define LSA_HALF_MSB    15
`define LSA_ZERO_WORD   32'h0000_0000
`endif

// ===== common/lsa_pkg.sv
package lsa_pkg;
	// operation requested by the decoder
	typedef enum logic [1:0] {LSA_OP_PCREL, LSA_OP_LOAD, LSA_OP_STORE} lsa_op_t;
	// transfer size and signedness
	typedef enum logic [2:0] {LSA_SZ_WORD, LSA_SZ_BYTE, LSA_SZ_HALF, LSA_SZ_SBYTE, LSA_SZ_SHALF,
		LSA_SZ_DUAL} lsa_size_t;
	// addressing mode
	typedef enum logic [1:0] {LSA_AM_OFFSET, LSA_AM_PRE, LSA_AM_POST} lsa_mode_t;
endpackage : lsa_pkg

// ===== tb/load_store_addr_extend_tb.sv
`timescale 1ns/10ps
module load_store_addr_extend_tb;
	logic               clock_in = 1'b0, rst_in = 1'b1, issue_in = 1'b0, cond_pass_in = 1'b0, subtract_in = 1'b0;
	lsa_pkg::lsa_op_t   op_in    = lsa_pkg::LSA_OP_PCREL;
	lsa_pkg::lsa_size_t size_in  = lsa_pkg::LSA_SZ_WORD;
	lsa_pkg::lsa_mode_t mode_in  = lsa_pkg::LSA_AM_OFFSET;
	logic [12:0]        offset_in = 13'h0;
	logic [31:0]        pc_in = 32'h0, base_in = 32'h0, store_data_in = 32'h0, store_data2_in = 32'h0;
	// never the stack pointer or program counter as destination
	logic [3:0]         base_reg_in = 4'h5, transfer_reg_in = 4'h2, second_transfer_reg_in = 4'h3;
	logic [3:0]         stall = 4'h0, mem_be_out, rf_waddr_out;
	logic [31:0]        mem_rdata_in, mem_addr_out, mem_wdata_out, rf_wdata_out;
	logic               mem_ready_in, busy_out, range_err_out, mem_req_out, mem_write_out, rf_we_out, flags_we_out;
	int                 n_fail = 0, compares = 0, n_err = 0, n_flag = 0;
	logic [35:0]        rq [$];
	logic [32:0]        mq [$];

	lsa_datapath lsa_datapath_i (.clock_in(clock_in), .rst_in(rst_in), .issue_in(issue_in),
		.cond_pass_in(cond_pass_in), .op_in(op_in), .size_in(size_in), .mode_in(mode_in),
		.subtract_in(subtract_in), .offset_in(offset_in), .pc_in(pc_in), .base_in(base_in),
		.base_reg_in(base_reg_in), .transfer_reg_in(transfer_reg_in),
		.second_transfer_reg_in(second_transfer_reg_in), .store_data_in(store_data_in),
		.store_data2_in(store_data2_in), .mem_ready_in(mem_ready_in), .mem_rdata_in(mem_rdata_in),
		.busy_out(busy_out), .range_err_out(range_err_out), .mem_req_out(mem_req_out),
		.mem_write_out(mem_write_out), .mem_addr_out(mem_addr_out), .mem_be_out(mem_be_out),
		.mem_wdata_out(mem_wdata_out), .rf_we_out(rf_we_out), .rf_waddr_out(rf_waddr_out),
		.rf_wdata_out(rf_wdata_out), .flags_we_out(flags_we_out));

	lsa_mem_model lsa_mem_model_i (.clock_in(clock_in), .rst_in(rst_in), .req_in(mem_req_out),
		.write_in(mem_write_out), .be_in(mem_be_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
		.stall_in(stall), .ready_out(mem_ready_in), .rdata_out(mem_rdata_in));

	always #20 clock_in = ~clock_in;

	// record register writes, memory accesses and pulses
	always @(posedge clock_in)
		if (!rst_in)
		begin
			if (rf_we_out) rq.push_back({rf_waddr_out, rf_wdata_out});
			if (mem_req_out && mem_ready_in) mq.push_back({mem_write_out, mem_addr_out});
			if (range_err_out) n_err++;
			if (flags_we_out) n_flag++;
		end

	task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task finish_test;
		if (n_fail == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	// offer one op for one cycle, then wait for idle and drain
	task automatic run_op(input lsa_pkg::lsa_op_t op, input lsa_pkg::lsa_size_t sz, input lsa_pkg::lsa_mode_t md,
		input logic sub, input logic [12:0] off, input logic [31:0] base, input logic cond);
		int n;
		rq.delete();
		mq.delete();
		n_err        = 0;
		op_in        = op;
		size_in      = sz;
		mode_in      = md;
		subtract_in  = sub;
		offset_in    = off;
		base_in      = base;
		cond_pass_in = cond;
		issue_in     = 1'b1;
		@(posedge clock_in);
		#1 issue_in  = 1'b0;
		n = 0;
		while (busy_out !== 1'b0 && n < 60)
		begin
			@(posedge clock_in);
			#1 n++;
		end
		chk("busy wait", 64'(n >= 60), 64'h0);
		repeat (3) @(posedge clock_in);
		#1;
	endtask : run_op

	task automatic pop_rf(input logic [3:0] ra, input logic [31:0] d);
		logic [35:0] v;
		v = (rq.size() > 0) ? rq.pop_front() : 36'hx;
		chk("register write", 64'(v), 64'({ra, d}));
	endtask : pop_rf

	task automatic pop_mem(input logic wr, input logic [31:0] a);
		logic [32:0] v;
		v = (mq.size() > 0) ? mq.pop_front() : 33'hx;
		chk("memory access", 64'(v), 64'({wr, a}));
	endtask : pop_mem

	task automatic none_left(input int errs);
		chk("extra traffic", 64'(rq.size() + mq.size()), 64'h0);
		chk("range error", 64'(n_err), 64'(errs));
	endtask : none_left

	task automatic ld_chk(input lsa_pkg::lsa_size_t sz, input logic [31:0] exp);
		run_op(lsa_pkg::LSA_OP_LOAD, sz, lsa_pkg::LSA_AM_OFFSET, 1'b0, 13'h0, 32'h40, 1'b1);
		pop_mem(1'b0, 32'h40);
		pop_rf(4'h2, exp);
		none_left(0);
	endtask : ld_chk

	task t_pcrel;
		pc_in = 32'h1000;
		run_op(lsa_pkg::LSA_OP_PCREL, lsa_pkg::LSA_SZ_WORD, lsa_pkg::LSA_AM_OFFSET, 1'b0, 13'hfff, 32'h0, 1'b1);
		pop_rf(4'h2, 32'h1fff);
		run_op(lsa_pkg::LSA_OP_PCREL, lsa_pkg::LSA_SZ_WORD, lsa_pkg::LSA_AM_OFFSET, 1'b1, 13'hfff, 32'h0, 1'b1);
		pop_rf(4'h2, 32'h1);
		chk("flag writes", 64'(n_flag), 64'h0);
		run_op(lsa_pkg::LSA_OP_PCREL, lsa_pkg::LSA_SZ_WORD, lsa_pkg::LSA_AM_OFFSET, 1'b0, 13'h1000, 32'h0, 1'b1);
		none_left(1);
	endtask : t_pcrel

	task t_loads;
		lsa_mem_model_i.mem[16] = 32'h1234_80f5;
		ld_chk(lsa_pkg::LSA_SZ_BYTE, 32'h0000_00f5);
		ld_chk(lsa_pkg::LSA_SZ_SBYTE, 32'hffff_fff5);
		ld_chk(lsa_pkg::LSA_SZ_HALF, 32'h0000_80f5);
		ld_chk(lsa_pkg::LSA_SZ_SHALF, 32'hffff_80f5);
		run_op(lsa_pkg::LSA_OP_LOAD, lsa_pkg::LSA_SZ_SBYTE, lsa_pkg::LSA_AM_OFFSET, 1'b0, 13'h1, 32'h40, 1'b1);
		pop_mem(1'b0, 32'h41);
		pop_rf(4'h2, 32'hffff_ff80);
		run_op(lsa_pkg::LSA_OP_LOAD, lsa_pkg::LSA_SZ_HALF, lsa_pkg::LSA_AM_OFFSET, 1'b0, 13'h2, 32'h40, 1'b1);
		pop_mem(1'b0, 32'h42);
		pop_rf(4'h2, 32'h0000_1234);
		run_op(lsa_pkg::LSA_OP_LOAD, lsa_pkg::LSA_SZ_WORD, lsa_pkg::LSA_AM_OFFSET, 1'b1, 13'h0ff, 32'h13f, 1'b1);
		pop_mem(1'b0, 32'h40);
		pop_rf(4'h2, 32'h1234_80f5);
		none_left(0);
		run_op(lsa_pkg::LSA_OP_LOAD, lsa_pkg::LSA_SZ_WORD, lsa_pkg::LSA_AM_OFFSET, 1'b0, 13'hfff, 32'h41, 1'b1);
		pop_mem(1'b0, 32'h1040);
		pop_rf(4'h2, 32'h1234_80f5);
		run_op(lsa_pkg::LSA_OP_LOAD, lsa_pkg::LSA_SZ_WORD, lsa_pkg::LSA_AM_OFFSET, 1'b1, 13'h100, 32'h140, 1'b1);
		none_left(1);
		run_op(lsa_pkg::LSA_OP_LOAD, lsa_pkg::LSA_SZ_WORD, lsa_pkg::LSA_AM_PRE, 1'b0, 13'h100, 32'h40, 1'b1);
		none_left(1);
	endtask : t_loads

	task t_index;
		run_op(lsa_pkg::LSA_OP_LOAD, lsa_pkg::LSA_SZ_WORD, lsa_pkg::LSA_AM_POST, 1'b0, 13'h8, 32'h40, 1'b1);
		pop_mem(1'b0, 32'h40);
		pop_rf(4'h2, 32'h1234_80f5);
		pop_rf(4'h5, 32'h48);
		store_data_in = 32'hcafe_0011;
		run_op(lsa_pkg::LSA_OP_STORE, lsa_pkg::LSA_SZ_WORD, lsa_pkg::LSA_AM_PRE, 1'b1, 13'h4, 32'h48, 1'b1);
		pop_mem(1'b1, 32'h44);
		pop_rf(4'h5, 32'h44);
		chk("stored word", 64'(lsa_mem_model_i.mem[17]), 64'h0000_0000_cafe_0011);
	endtask : t_index

	task t_dual;
		stall = 4'h3;
		run_op(lsa_pkg::LSA_OP_LOAD, lsa_pkg::LSA_SZ_DUAL, lsa_pkg::LSA_AM_OFFSET, 1'b0, 13'h10, 32'h30, 1'b1);
		pop_mem(1'b0, 32'h40);
		pop_mem(1'b0, 32'h44);
		pop_rf(4'h2, 32'h1234_80f5);
		pop_rf(4'h3, 32'hcafe_0011);
		store_data2_in = 32'h5566_7788;
		run_op(lsa_pkg::LSA_OP_STORE, lsa_pkg::LSA_SZ_DUAL, lsa_pkg::LSA_AM_POST, 1'b1, 13'h3fc, 32'h400, 1'b1);
		pop_mem(1'b1, 32'h400);
		pop_mem(1'b1, 32'h404);
		pop_rf(4'h5, 32'h4);
		chk("dual word 2", 64'(lsa_mem_model_i.mem[1]), 64'h0000_0000_5566_7788);
		run_op(lsa_pkg::LSA_OP_LOAD, lsa_pkg::LSA_SZ_DUAL, lsa_pkg::LSA_AM_OFFSET, 1'b0, 13'h6, 32'h40, 1'b1);
		none_left(1);
		stall = 4'h0;
	endtask : t_dual

	task t_narrow;
		lsa_mem_model_i.mem[20] = 32'haaaa_aaaa;
		store_data_in = 32'h1234_5678;
		run_op(lsa_pkg::LSA_OP_STORE, lsa_pkg::LSA_SZ_BYTE, lsa_pkg::LSA_AM_OFFSET, 1'b0, 13'h0, 32'h50, 1'b1);
		chk("byte store", 64'(lsa_mem_model_i.mem[20]), 64'h0000_0000_aaaa_aa78);
		run_op(lsa_pkg::LSA_OP_STORE, lsa_pkg::LSA_SZ_HALF, lsa_pkg::LSA_AM_OFFSET, 1'b0, 13'h0, 32'h50, 1'b1);
		chk("half store", 64'(lsa_mem_model_i.mem[20]), 64'h0000_0000_aaaa_5678);
		run_op(lsa_pkg::LSA_OP_STORE, lsa_pkg::LSA_SZ_BYTE, lsa_pkg::LSA_AM_OFFSET, 1'b0, 13'h3, 32'h50, 1'b1);
		chk("lane store", 64'(lsa_mem_model_i.mem[20]), 64'h0000_0000_78aa_5678);
	endtask : t_narrow

	task t_cond;
		run_op(lsa_pkg::LSA_OP_LOAD, lsa_pkg::LSA_SZ_WORD, lsa_pkg::LSA_AM_POST, 1'b0, 13'h8, 32'h40, 1'b0);
		none_left(0);
		run_op(lsa_pkg::LSA_OP_PCREL, lsa_pkg::LSA_SZ_WORD, lsa_pkg::LSA_AM_OFFSET, 1'b0, 13'h4, 32'h0, 1'b0);
		none_left(0);
	endtask : t_cond

	// cut a hang short
	initial
	begin
		#200000;
		n_fail++;
		finish_test;
	end

	initial
	begin
		repeat (3) @(posedge clock_in);
		#1 rst_in = 1'b0;
		t_pcrel;
		t_loads;
		t_index;
		t_dual;
		t_narrow;
		t_cond;
		finish_test;
	end
endmodule : load_store_addr_extend_tb

// ===== tb/lsa_mem_model.sv
`timescale 1ns/10ps
// data memory on the far side of the load/store path
module lsa_mem_model (
	input  wire logic        clock_in, // core clock
	input  wire logic        rst_in,   // sync reset
	input  wire logic        req_in,   // access request
	input  wire logic        write_in, // store when high
	input  wire logic [3:0]  be_in,    // byte lanes
	input  wire logic [31:0] addr_in,  // byte address
	input  wire logic [31:0] wdata_in, // store data
	input  wire logic [3:0]  stall_in, // wait cycles before answering
	output logic             ready_out, // accept / answer
	output logic      [31:0] rdata_out  // read data, valid with ready
);
	logic [31:0] mem [0:63];
	logic [3:0]  cnt;
	logic        took;

	initial
	begin
		ready_out = 1'b0;
		rdata_out = 32'h0;
		cnt       = 4'h0;
	end

	// sample the edge, then answer just after it
	always @(posedge clock_in)
	begin
		took = req_in && ready_out;
		if (took && write_in)
			for (int k = 0; k < 4; k++)
				if (be_in[k])
					mem[addr_in[7:2]][8*k +: 8] = wdata_in[8*k +: 8];
		#1;
		if (rst_in || took || !req_in)
		begin
			ready_out = 1'b0;
			cnt       = 4'h0;
			rdata_out = ~rdata_out; // stale data never looks valid
		end
		else if (cnt >= stall_in)
		begin
			ready_out = 1'b1;
			rdata_out = mem[addr_in[7:2]];
		end
		else
		begin
			cnt       = cnt + 4'h1;
			rdata_out = ~rdata_out;
		end
	end
endmodule : lsa_mem_model

// ===== verilog/lsa_datapath.sv
`timescale 1ns/10ps
`include "lsa_defines.svh"
// Function
// [RULE_01] pc-relative: pc plus immediate into destination
// [RULE_02] pc displacement limited to plus/minus 4095
// [RULE_03] software never targets sp or pc
// [RULE_04] pc-relative op leaves flags untouched
// [RULE_05] software sets bit zero for exchange targets
// [RULE_06] unsigned byte load zero extends
// [RULE_07] signed byte load replicates bit seven
// [RULE_08] unsigned halfword load zero extends
// [RULE_09] signed halfword load replicates bit fifteen
// [RULE_10] no offset uses base unchanged
// [RULE_11] dual forms move two consecutive words
// [RULE_12] offset mode leaves base unmodified
// [RULE_13] post-index accesses base, then writes back
// [RULE_14] offset ranges checked per form
// [RULE_15] narrow stores drive only low bits
// [RULE_16] failed condition: no access, no writeback
module lsa_datapath (
	input  wire logic                   clock_in,       // core clock
	input  wire logic                   rst_in,         // sync reset
	input  wire logic                   issue_in,       // decoder issues op
	input  wire logic                   cond_pass_in,   // condition code true
	input  wire lsa_pkg::lsa_op_t       op_in,          // operation
	input  wire lsa_pkg::lsa_size_t     size_in,        // transfer size
	input  wire lsa_pkg::lsa_mode_t     mode_in,        // addressing mode
	input  wire logic                   subtract_in,    // offset sign
	input  wire logic [12:0]            offset_in,      // offset magnitude
	input  wire logic [`LSA_DATA_W-1:0] pc_in,          // program counter
	input  wire logic [`LSA_DATA_W-1:0] base_in,        // base_reg value
	input  wire logic [`LSA_REG_W-1:0]  base_reg_in,    // base_reg index
	input  wire logic [`LSA_REG_W-1:0]  transfer_reg_in,        // transfer_reg index
	input  wire logic [`LSA_REG_W-1:0]  second_transfer_reg_in, // second_transfer_reg index
	input  wire logic [`LSA_DATA_W-1:0] store_data_in,  // transfer_reg value
	input  wire logic [`LSA_DATA_W-1:0] store_data2_in, // second_transfer_reg value
	input  wire logic                   mem_ready_in,   // memory accepts/answers
	input  wire logic [`LSA_DATA_W-1:0] mem_rdata_in,   // memory read data
	output logic                        busy_out,       // block not idle
	output logic                        range_err_out,  // offset out of range pulse
	output logic                        mem_req_out,    // memory request
	output logic                        mem_write_out,  // store when high
	output logic [`LSA_DATA_W-1:0]      mem_addr_out,   // memory address
	output logic [3:0]                  mem_be_out,     // byte lanes
	output logic [`LSA_DATA_W-1:0]      mem_wdata_out,  // store data
	output logic                        rf_we_out,      // register write pulse
	output logic [`LSA_REG_W-1:0]       rf_waddr_out,   // register index
	output logic [`LSA_DATA_W-1:0]      rf_wdata_out,   // register data
	output logic                        flags_we_out    // flag update, always low
);
	typedef enum logic [2:0] {ST_IDLE, ST_MEM1, ST_MEM2, ST_LOADWB1, ST_LOADWB2, ST_BASEWB} lsa_st_t;
	typedef struct packed {
		lsa_st_t                 st;
		logic                    write;
		lsa_pkg::lsa_size_t      size;
		logic [`LSA_DATA_W-1:0]  addr;
		logic [`LSA_DATA_W-1:0]  wdata2;
		logic [`LSA_DATA_W-1:0]  newbase;
		logic                    base_wb;
		logic [`LSA_REG_W-1:0]   rt;
		logic [`LSA_REG_W-1:0]   rt2;
		logic [`LSA_REG_W-1:0]   rn;
		logic [`LSA_DATA_W-1:0]  wdata;
		logic                    rf_we;
		logic [`LSA_REG_W-1:0]   rf_waddr;
		logic [`LSA_DATA_W-1:0]  rf_wdata;
		logic                    err;
	} lsa_dp_state_t;
	lsa_dp_state_t state;
	lsa_dp_state_t next_state;

	logic [`LSA_DATA_W-1:0] ext_word;
	logic                   ext_valid;
	logic [`LSA_DATA_W-1:0] offset_val;
	logic [`LSA_DATA_W-1:0] sum;
	logic                   in_range;
	logic [`LSA_DATA_W-1:0] lane_data;

	// offset range check per form
	function automatic logic offset_ok(input lsa_pkg::lsa_op_t op, input lsa_pkg::lsa_size_t sz,
		input lsa_pkg::lsa_mode_t md, input logic neg, input logic [12:0] mag);
		offset_ok = 1'b1;
		if (op == lsa_pkg::LSA_OP_PCREL)
			offset_ok = (mag <= 13'(`LSA_PCREL_MAX)); // RULE_02
		else if (sz == lsa_pkg::LSA_SZ_DUAL)
			offset_ok = (mag <= 13'(`LSA_DUAL_MAX)) && (mag[1:0] == 2'h0); // RULE_14
		else if (md == lsa_pkg::LSA_AM_OFFSET)
			offset_ok = neg ? (mag <= 13'(`LSA_IMM_NEG_MAX)) : (mag <= 13'(`LSA_IMM_POS_MAX)); // RULE_14
		else
			offset_ok = (mag <= 13'(`LSA_IDX_MAX)); // RULE_14
	endfunction : offset_ok

	// byte lanes for a size and address
	function automatic logic [3:0] lanes(input lsa_pkg::lsa_size_t sz, input logic [1:0] a);
		case (sz)
			lsa_pkg::LSA_SZ_BYTE, lsa_pkg::LSA_SZ_SBYTE:  lanes = 4'h1 << a;
			lsa_pkg::LSA_SZ_HALF, lsa_pkg::LSA_SZ_SHALF:  lanes = a[1] ? 4'hc : 4'h3;
			default:                                      lanes = 4'hf;
		endcase
	endfunction : lanes

	// store data placed on lanes, upper source bits dropped
	function automatic logic [`LSA_DATA_W-1:0] place(input lsa_pkg::lsa_size_t sz,
		input logic [`LSA_DATA_W-1:0] d);
		case (sz)
			lsa_pkg::LSA_SZ_BYTE:  place = {4{d[`LSA_BYTE_MSB:0]}}; // RULE_15
			lsa_pkg::LSA_SZ_HALF:  place = {2{d[`LSA_HALF_MSB:0]}}; // RULE_15
			default:               place = d;
		endcase
	endfunction : place

	// signed offset and sum; zero offset gives the base itself
	assign offset_val = subtract_in ? (`LSA_ZERO_WORD - {19'h0_0000, offset_in}) : {19'h0_0000, offset_in};
	assign sum        = ((op_in == lsa_pkg::LSA_OP_PCREL) ? pc_in : base_in) + offset_val; // RULE_01 RULE_10 RULE_12
	assign in_range   = offset_ok(op_in, size_in, mode_in, subtract_in, offset_in);
	assign ext_valid  = (state.st == ST_MEM1 || state.st == ST_MEM2) && mem_ready_in && !state.write;

	// narrow loads: addressed lane moved down to bit zero before extension
	assign lane_data  = (state.size == lsa_pkg::LSA_SZ_WORD || state.size == lsa_pkg::LSA_SZ_DUAL) ? mem_rdata_in
		: (mem_rdata_in >> {state.addr[1:0], 3'h0}); // RULE_06 RULE_07 RULE_08 RULE_09

	lsa_extend u_extend (
		.clock_in (clock_in),
		.rst_in   (rst_in),
		.valid_in (ext_valid),
		.size_in  (state.size),
		.raw_in   (lane_data),
		.word_out (ext_word)
	);

	// sequencer
	always_comb
	begin
		next_state       = state;
		next_state.rf_we = 1'b0;
		next_state.err   = 1'b0;
		case (state.st)
			ST_IDLE:
			begin
				if (issue_in && cond_pass_in) // RULE_16
				begin
					if (!in_range)
						next_state.err = 1'b1;
					else if (op_in == lsa_pkg::LSA_OP_PCREL)
					begin
						next_state.rf_we    = 1'b1; // RULE_01 RULE_04
						next_state.rf_waddr = transfer_reg_in; // RULE_03
						next_state.rf_wdata = sum;
					end
					else
					begin
						next_state.write   = (op_in == lsa_pkg::LSA_OP_STORE);
						next_state.size    = size_in;
						next_state.addr    = (mode_in == lsa_pkg::LSA_AM_POST) ? base_in : sum; // RULE_13
						next_state.newbase = sum;
						next_state.base_wb = (mode_in != lsa_pkg::LSA_AM_OFFSET); // RULE_12 RULE_13
						next_state.rt      = transfer_reg_in;
						next_state.rt2     = second_transfer_reg_in;
						next_state.rn      = base_reg_in;
						next_state.wdata   = place(size_in, store_data_in); // RULE_15
						next_state.wdata2  = store_data2_in;
						next_state.st      = ST_MEM1;
					end
				end
			end
			ST_MEM1:
				if (mem_ready_in)
				begin
					if (state.size == lsa_pkg::LSA_SZ_DUAL)
					begin
						next_state.st   = ST_MEM2; // RULE_11
						next_state.addr = state.addr + `LSA_WORD_BYTES;
					end
					else
						next_state.st = state.write ? (state.base_wb ? ST_BASEWB : ST_IDLE) : ST_LOADWB1;
				end
			ST_LOADWB1:
			begin
				next_state.rf_we    = 1'b1;
				next_state.rf_waddr = state.rt;
				next_state.rf_wdata = ext_word;
				next_state.st       = state.base_wb ? ST_BASEWB : ST_IDLE;
			end
			ST_MEM2:
				if (mem_ready_in)
				begin
					next_state.rf_we    = !state.write; // RULE_11
					next_state.rf_waddr = state.rt;
					next_state.rf_wdata = ext_word;
					next_state.st       = state.write ? (state.base_wb ? ST_BASEWB : ST_IDLE) : ST_LOADWB2;
				end
			ST_LOADWB2:
			begin
				next_state.rf_we    = 1'b1;
				next_state.rf_waddr = state.rt2;
				next_state.rf_wdata = ext_word;
				next_state.st       = state.base_wb ? ST_BASEWB : ST_IDLE;
			end
			ST_BASEWB:
			begin
				next_state.rf_we    = 1'b1; // RULE_13
				next_state.rf_waddr = state.rn;
				next_state.rf_wdata = state.newbase;
				next_state.st       = ST_IDLE;
			end
			default: next_state.st = ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			state    <= '0;
			state.st <= ST_IDLE;
		end
		else
			state <= next_state;
	end

	// outputs
	assign busy_out      = (state.st != ST_IDLE);
	assign range_err_out = state.err;
	assign mem_req_out   = (state.st == ST_MEM1) || (state.st == ST_MEM2);
	assign mem_write_out = state.write;
	assign mem_addr_out  = state.addr;
	assign mem_be_out    = lanes(state.size, state.addr[1:0]);
	assign mem_wdata_out = (state.st == ST_MEM2) ? state.wdata2 : state.wdata;
	assign rf_we_out     = state.rf_we;
	assign rf_waddr_out  = state.rf_waddr;
	assign rf_wdata_out  = state.rf_wdata;
	assign flags_we_out  = 1'b0; // RULE_04

	// properties
	property p_cond_fail;
		@(posedge clock_in) disable iff (rst_in)
		!busy_out && issue_in && !cond_pass_in |=> !mem_req_out && !rf_we_out;
	endproperty
	a_cond_fail: assert property (p_cond_fail) else $error("failed condition caused activity"); // RULE_16
	property p_pcrel;
		@(posedge clock_in) disable iff (rst_in)
		!busy_out && issue_in && cond_pass_in && op_in == lsa_pkg::LSA_OP_PCREL && in_range
		|=> rf_we_out && rf_wdata_out == $past(pc_in) + $past(offset_val);
	endproperty
	a_pcrel: assert property (p_pcrel) else $error("pc-relative result wrong"); // RULE_01
	property p_no_flags;
		@(posedge clock_in) disable iff (rst_in) !flags_we_out;
	endproperty
	a_no_flags: assert property (p_no_flags) else $error("flags written"); // RULE_04
	property p_post_addr;
		@(posedge clock_in) disable iff (rst_in)
		!busy_out && issue_in && cond_pass_in && in_range && op_in != lsa_pkg::LSA_OP_PCREL
		&& mode_in == lsa_pkg::LSA_AM_POST |=> mem_req_out && mem_addr_out == $past(base_in);
	endproperty
	a_post_addr: assert property (p_post_addr) else $error("post-index address not base"); // RULE_13
	property p_offset_addr;
		@(posedge clock_in) disable iff (rst_in)
		!busy_out && issue_in && cond_pass_in && in_range && op_in != lsa_pkg::LSA_OP_PCREL
		&& mode_in != lsa_pkg::LSA_AM_POST |=> mem_addr_out == $past(base_in) + $past(offset_val);
	endproperty
	a_offset_addr: assert property (p_offset_addr) else $error("offset address wrong"); // RULE_12
	property p_range;
		@(posedge clock_in) disable iff (rst_in)
		!busy_out && issue_in && cond_pass_in && !in_range |=> range_err_out && !busy_out;
	endproperty
	a_range: assert property (p_range) else $error("out of range offset accepted"); // RULE_14
	property p_dual_step;
		@(posedge clock_in) disable iff (rst_in)
		state.st == ST_MEM1 && mem_ready_in && state.size == lsa_pkg::LSA_SZ_DUAL
		|=> mem_req_out && mem_addr_out == $past(mem_addr_out) + 32'h0000_0004;
	endproperty
	a_dual_step: assert property (p_dual_step) else $error("second word address wrong"); // RULE_11
	property p_no_base_wb;
		@(posedge clock_in) disable iff (rst_in)
		!state.base_wb && busy_out |-> state.st != ST_BASEWB;
	endproperty
	a_no_base_wb: assert property (p_no_base_wb) else $error("offset mode wrote base"); // RULE_12
	property p_byte_store;
		@(posedge clock_in) disable iff (rst_in)
		!busy_out && issue_in && cond_pass_in && in_range && op_in == lsa_pkg::LSA_OP_STORE
		&& size_in == lsa_pkg::LSA_SZ_BYTE |=> mem_wdata_out == {4{$past(store_data_in[7:0])}};
	endproperty
	a_byte_store: assert property (p_byte_store) else $error("byte store lanes wrong"); // RULE_15
endmodule : lsa_datapath

// ===== verilog/lsa_extend.sv
`timescale 1ns/10ps
`include "lsa_defines.svh"
// registered load data extender
module lsa_extend (
	input  wire logic                   clock_in,  // core clock
	input  wire logic                   rst_in,    // sync reset
	input  wire logic                   valid_in,  // load data present
	input  wire lsa_pkg::lsa_size_t     size_in,   // transfer size
	input  wire logic [`LSA_DATA_W-1:0] raw_in,    // fetched data
	output logic      [`LSA_DATA_W-1:0] word_out   // extended word
);
	typedef struct packed { logic [`LSA_DATA_W-1:0] word; } lsa_ext_state_t;
	lsa_ext_state_t state;
	lsa_ext_state_t next_state;

	// extension by size
	always_comb
	begin
		next_state = state;
		if (valid_in)
		begin
			case (size_in)
				lsa_pkg::LSA_SZ_BYTE:  next_state.word = {24'h00_0000, raw_in[`LSA_BYTE_MSB:0]}; // RULE_06
				lsa_pkg::LSA_SZ_SBYTE: next_state.word = {{24{raw_in[`LSA_BYTE_MSB]}},
					raw_in[`LSA_BYTE_MSB:0]}; // RULE_07
				lsa_pkg::LSA_SZ_HALF:  next_state.word = {16'h0000, raw_in[`LSA_HALF_MSB:0]}; // RULE_08
				lsa_pkg::LSA_SZ_SHALF: next_state.word = {{16{raw_in[`LSA_HALF_MSB]}},
					raw_in[`LSA_HALF_MSB:0]}; // RULE_09
				default:               next_state.word = raw_in;
			endcase
		end
	end

	// state register
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			state <= '0;
		else
			state <= next_state;
	end

	assign word_out = state.word;

	// properties
	property p_byte_zero;
		@(posedge clock_in) disable iff (rst_in)
		valid_in && size_in == lsa_pkg::LSA_SZ_BYTE |=> word_out[31:8] == 24'h00_0000;
	endproperty
	a_byte_zero: assert property (p_byte_zero) else $error("byte load not zero extended"); // RULE_06
	property p_sbyte;
		@(posedge clock_in) disable iff (rst_in)
		valid_in && size_in == lsa_pkg::LSA_SZ_SBYTE |=>
			word_out == {{24{$past(raw_in[7])}}, $past(raw_in[7:0])};
	endproperty
	a_sbyte: assert property (p_sbyte) else $error("signed byte load wrong"); // RULE_07
	property p_half_zero;
		@(posedge clock_in) disable iff (rst_in)
		valid_in && size_in == lsa_pkg::LSA_SZ_HALF |=> word_out == {16'h0000, $past(raw_in[15:0])};
	endproperty
	a_half_zero: assert property (p_half_zero) else $error("halfword load not zero extended"); // RULE_08
	property p_shalf;
		@(posedge clock_in) disable iff (rst_in)
		valid_in && size_in == lsa_pkg::LSA_SZ_SHALF |=>
			word_out == {{16{$past(raw_in[15])}}, $past(raw_in[15:0])};
	endproperty
	a_shalf: assert property (p_shalf) else $error("signed halfword load wrong"); // RULE_09
endmodule : lsa_extend
